/* File: verilog/mst_defines.svh */
// Constants of the micro-step translator: register map, field positions,
// reset values and timing. Assumes a 100 MHz core clock.
`ifndef MST_DEFINES_SVH
`define MST_DEFINES_SVH

// Register byte offsets on the Wishbone slave.
`define MST_OFS_CTRL       8'h00
`define MST_OFS_CURRENT    8'h04
`define MST_OFS_POSITION   8'h08
`define MST_OFS_COIL       8'h0C

// Field positions.
`define MST_CTRL_MODE_LSB  0
`define MST_CTRL_MODE_MSB  2
`define MST_CTRL_DIR_BIT   3
`define MST_CTRL_POL_BIT   4
`define MST_CUR_MSB        4
`define MST_POS_MSB        6
`define MST_POS_MODE_LSB   8
`define MST_POS_MODE_MSB   10

// Reset values.
`define MST_RST_MODE       3'h0
`define MST_RST_CURRENT    5'h00
`define MST_RST_POSITION   7'h00

// Timing: clock period and the PWM period, both in ns.
`define MST_CLK_PERIOD_NS  10
`define MST_PWM_PERIOD_NS  50000

`endif

/* File: verilog/mst_pkg.sv */
// Types of the micro-step translator.
// Assumes the constants of mst_defines.svh for the widths they share.
package mst_pkg;

    // Step resolutions; the last three all move a full step.
    typedef enum logic [2:0] {
        MST_STEP_32   = 3'h0,
        MST_STEP_16   = 3'h1,
        MST_STEP_8    = 3'h2,
        MST_STEP_4    = 3'h3,
        MST_STEP_2    = 3'h4,
        MST_STEP_F0   = 3'h5,
        MST_STEP_F1   = 3'h6,
        MST_STEP_F2   = 3'h7
    } mst_mode_t;

    // Software control fields.
    typedef struct packed {
        logic      step_edge_polarity;
        logic      direction_control_bit;
        mst_mode_t step_mode;
    } mst_ctrl_t;

    // Scaled coil current targets, signed.
    typedef struct packed {
        logic signed [15:0] coil_y;
        logic signed [15:0] coil_x;
    } mst_coil_t;

endpackage

/* File: verilog/mst_translator.sv */
// Micro-step current translator with a classic Wishbone register slave.
// Assumes step and direction arrive asynchronously from a controller pin;
// the bus master is on core_clk.
`timescale 1ns/100ps
`include "mst_defines.svh"

module mst_translator #(
    parameter int PWM_CYCLES = `MST_PWM_PERIOD_NS / `MST_CLK_PERIOD_NS
) (
    // Clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // Controller pins.
    input  wire logic              step_pulse_input,
    input  wire logic              dir_pin,
    // Wishbone slave.
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [7:0]        wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_dat_w,
    output logic      [31:0]       wb_dat_r,
    output logic                   wb_ack,
    // Translator outputs.
    output logic      [6:0]        translator_position,
    output mst_pkg::mst_coil_t     coil_target,
    output logic                   pwm_period_tick
);

    // Register state.
    mst_pkg::mst_ctrl_t  ctrl;
    logic [4:0]          peak_current_setting;
    mst_pkg::mst_mode_t  active_mode;
    logic [6:0]          next_position;
    // Pin synchronisers and edge detection.
    logic [1:0]          step_sync;
    logic [1:0]          dir_sync;
    logic                step_last;
    logic                step_fire;
    logic                step_up;
    // PWM period divider.
    logic [31:0]         pwm_count;
    // Bus decode.
    logic                bus_req;
    logic                bus_wr;

    // Step size in 1/32 units for a resolution.
    function automatic logic [6:0] step_size(input mst_pkg::mst_mode_t m);
        case (m)
            mst_pkg::MST_STEP_32: step_size = 7'h01;
            mst_pkg::MST_STEP_16: step_size = 7'h02;
            mst_pkg::MST_STEP_8:  step_size = 7'h04;
            mst_pkg::MST_STEP_4:  step_size = 7'h08;
            mst_pkg::MST_STEP_2:  step_size = 7'h10;
            default:              step_size = 7'h20;
        endcase
    endfunction

    // Quarter-wave magnitude in tenths of a percent, 0 at 0 and 1000 at 32.
    function automatic logic [9:0] quarter_mag(input logic [5:0] k);
        case (k)
            6'h00: quarter_mag = 10'h000;
            6'h01: quarter_mag = 10'h023;
            6'h02: quarter_mag = 10'h051;
            6'h03: quarter_mag = 10'h07F;
            6'h04: quarter_mag = 10'h0AE;
            6'h05: quarter_mag = 10'h0DD;
            6'h06: quarter_mag = 10'h10B;
            6'h07: quarter_mag = 10'h13A;
            6'h08: quarter_mag = 10'h15D;
            6'h09: quarter_mag = 10'h17F;
            6'h0A: quarter_mag = 10'h1AE;
            6'h0B: quarter_mag = 10'h1D1;
            6'h0C: quarter_mag = 10'h1F4;
            6'h0D: quarter_mag = 10'h222;
            6'h0E: quarter_mag = 10'h245;
            6'h0F: quarter_mag = 10'h268;
            6'h10: quarter_mag = 10'h28B;
            6'h11: quarter_mag = 10'h2AE;
            6'h12: quarter_mag = 10'h2D1;
            6'h13: quarter_mag = 10'h2F3;
            6'h14: quarter_mag = 10'h316;
            6'h15: quarter_mag = 10'h33A;
            6'h16: quarter_mag = 10'h351;
            6'h17: quarter_mag = 10'h368;
            6'h18: quarter_mag = 10'h37F;
            6'h19: quarter_mag = 10'h396;
            6'h1A: quarter_mag = 10'h3A2;
            6'h1B: quarter_mag = 10'h3AD;
            6'h1C: quarter_mag = 10'h3B9;
            6'h1D: quarter_mag = 10'h3C5;
            6'h1E: quarter_mag = 10'h3D1;
            6'h1F: quarter_mag = 10'h3DC;
            default: quarter_mag = 10'h3E8;
        endcase
    endfunction

    // Signed coil percentage (tenths) at a position: sine, zero at 0,
    // +100 % at 32, zero at 64, -100 % at 96.
    function automatic logic signed [10:0] sine_tenths(input logic [6:0] p);
        logic [5:0] k;
        logic [9:0] m;
        k = p[5] ? 6'(7'h40 - {1'b0, p[5:0]}) : p[5:0];
        m = quarter_mag(k);
        sine_tenths = p[6] ? -$signed({1'b0, m}) : $signed({1'b0, m});
    endfunction

    // Two flip-flops on each asynchronous pin before any logic reads it.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            step_sync <= 2'h0;
            dir_sync  <= 2'h0;
        end else begin
            step_sync <= {step_sync[0], step_pulse_input};
            dir_sync  <= {dir_sync[0], dir_pin};
        end
    end

    // Edge history, taken from the second synchroniser stage only.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            step_last <= 1'b0;
        end else begin
            step_last <= step_sync[1];
        end
    end

    // steps even with drivers disabled; no enable gates this.
    assign step_fire = ctrl.step_edge_polarity ? (step_last && !step_sync[1])
                                               : (!step_last && step_sync[1]);

    assign step_up = dir_sync[1] ^ ctrl.direction_control_bit;

    // Next position on a step, using the newly programmed resolution.
    always_comb begin
        logic [6:0] sz;
        logic [6:0] base;
        sz   = step_size(ctrl.step_mode);
        base = translator_position;
        // snap to nearest finer grid point.
        if (sz < step_size(active_mode)) begin
            base = (translator_position + (sz >> 1)) & ~(sz - 7'h01);
        end
        next_position = step_up ? base + sz : base - sz;
    end

    // position updated on the step edge.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            translator_position <= `MST_RST_POSITION;
            active_mode         <= mst_pkg::mst_mode_t'(`MST_RST_MODE);
        end else if (step_fire) begin
            translator_position <= next_position;
            active_mode         <= ctrl.step_mode;
        end
    end

    // PWM period divider; the tick starts each new period.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pwm_count       <= 32'h0;
            pwm_period_tick <= 1'b0;
        end else if (pwm_count >= 32'(PWM_CYCLES - 1)) begin
            pwm_count       <= 32'h0;
            pwm_period_tick <= 1'b1;
        end else begin
            pwm_count       <= pwm_count + 32'h1;
            pwm_period_tick <= 1'b0;
        end
    end

    // sine for X, cosine for Y.
    // Position and current are sampled together, so a target never mixes
    // an old amplitude with a new one inside one PWM period.
    // Both factors are widened to 16 bits first, so the product of up to
    // 1000 tenths and a setting of 31 (31000) cannot overflow the 16-bit signed result.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            coil_target <= '0;
        end else if (pwm_period_tick) begin
            coil_target.coil_x <= 16'(sine_tenths(translator_position))
                                  * 16'($signed({1'b0, peak_current_setting}));
            coil_target.coil_y <= 16'(sine_tenths(7'(translator_position + 7'h20)))
                                  * 16'($signed({1'b0, peak_current_setting}));
        end
    end

    // Bus decode: writes land on the edge where ack is sampled high.
    assign bus_req = wb_cyc && wb_stb;
    assign bus_wr  = bus_req && wb_we && wb_ack && wb_sel[0];

    // Ack one cycle after the request, dropped the cycle after.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= bus_req && !wb_ack;
        end
    end

    // five-bit peak current.
    // Control and current registers; all fields sit in byte lane 0.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl.step_mode             <= mst_pkg::mst_mode_t'(`MST_RST_MODE);
            ctrl.direction_control_bit <= 1'b0;
            ctrl.step_edge_polarity    <= 1'b0;
            peak_current_setting       <= `MST_RST_CURRENT;
        end else if (bus_wr) begin
            if (wb_adr == `MST_OFS_CTRL) begin
                ctrl.step_mode <= mst_pkg::mst_mode_t'(
                    wb_dat_w[`MST_CTRL_MODE_MSB:`MST_CTRL_MODE_LSB]);
                ctrl.direction_control_bit <= wb_dat_w[`MST_CTRL_DIR_BIT];
                ctrl.step_edge_polarity    <= wb_dat_w[`MST_CTRL_POL_BIT];
            end
            if (wb_adr == `MST_OFS_CURRENT) begin
                peak_current_setting <= wb_dat_w[`MST_CUR_MSB:0];
            end
        end
    end

    // position read as 7 bits.
    // Read data is captured as ack rises; unmapped offsets read zero.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wb_dat_r <= 32'h0;
        end else if (bus_req && !wb_ack) begin
            wb_dat_r <= 32'h0;
            case (wb_adr)
                `MST_OFS_CTRL: begin
                    wb_dat_r[`MST_CTRL_MODE_MSB:`MST_CTRL_MODE_LSB] <= ctrl.step_mode;
                    wb_dat_r[`MST_CTRL_DIR_BIT] <= ctrl.direction_control_bit;
                    wb_dat_r[`MST_CTRL_POL_BIT] <= ctrl.step_edge_polarity;
                end
                `MST_OFS_CURRENT: begin
                    wb_dat_r[`MST_CUR_MSB:0] <= peak_current_setting;
                end
                `MST_OFS_POSITION: begin
                    wb_dat_r[`MST_POS_MSB:0] <= translator_position;
                    wb_dat_r[`MST_POS_MODE_MSB:`MST_POS_MODE_LSB] <= active_mode;
                end
                `MST_OFS_COIL: begin
                    wb_dat_r <= coil_target;
                end
                default: begin
                    wb_dat_r <= 32'h0;
                end
            endcase
        end
    end

endmodule

/* File: sim/mst_checker.sv */
// Checker for the micro-step translator, watching its ports only.
// Assumes it is bound onto mst_translator with the same PWM_CYCLES.
`timescale 1ns/100ps
module mst_checker #(
    parameter int PWM_CYCLES = 8
) (
    // Clock and reset.
    input wire logic               core_clk,
    input wire logic               rstn,
    // Pins and bus.
    input wire logic               step_pulse_input,
    input wire logic               wb_cyc,
    input wire logic               wb_stb,
    input wire logic [31:0]        wb_dat_r,
    input wire logic               wb_ack,
    // Translator outputs.
    input wire logic [6:0]         translator_position,
    input wire mst_pkg::mst_coil_t coil_target,
    input wire logic               pwm_period_tick
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic        prev_pin;
    logic [3:0]  pin_age;
    logic [15:0] gap;
    logic        seen;
    // Cycles since the pin last moved; saturates so it never wraps back.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            prev_pin <= 1'b0;
            pin_age  <= 4'hF;
        end else begin
            prev_pin <= step_pulse_input;
            pin_age  <= (prev_pin != step_pulse_input) ? 4'h0 :
                        (pin_age == 4'hF) ? pin_age : pin_age + 4'h1;
        end
    end
    // Cycles since the last PWM tick; seen marks that one has occurred.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gap  <= 16'h0;
            seen <= 1'b0;
        end else begin
            gap  <= pwm_period_tick ? 16'h0 : gap + 16'h1;
            seen <= seen | pwm_period_tick;
        end
    end
    sequence bus_req;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    ack_after_req_a: assert property (bus_req |=> wb_ack)
        else $error("no ack one cycle after request");
    ack_single_a: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    rdata_hold_a: assert property ($changed(wb_dat_r) |-> wb_ack)
        else $error("read data moved outside ack");
    pos_needs_edge_a: assert property ($changed(translator_position) |-> pin_age < 4'h5)
        else $error("position moved without a pin edge");
    coil_on_tick_a: assert property ($changed(coil_target) |-> $past(pwm_period_tick))
        else $error("coil target moved off the period tick");
    tick_gap_a: assert property (seen |-> gap < PWM_CYCLES)
        else $error("period tick overdue");
    tick_exact_a: assert property (pwm_period_tick && seen |-> gap == PWM_CYCLES - 1)
        else $error("period tick early");
endmodule
bind mst_translator mst_checker #(.PWM_CYCLES(PWM_CYCLES)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .step_pulse_input(step_pulse_input),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .translator_position(translator_position), .coil_target(coil_target),
    .pwm_period_tick(pwm_period_tick));

/* File: sim/mst_ctl_model.sv */
// Controller model that drives the step and direction pins.
// Assumes the bench calls its tasks; pins change just after a rising edge.
`timescale 1ns/100ps
module mst_ctl_model (
    // Clock.
    input  wire logic core_clk,
    // Pins toward the translator.
    output logic      step_pulse_input,
    output logic      dir_pin
);
    // Pin levels before the first call.
    initial begin
        step_pulse_input = 1'b0;
        dir_pin = 1'b1;
    end
    // Holding a level for fewer than two cycles would let the synchroniser miss it.
    task drive(input logic v, input int hold);
        @(posedge core_clk);
        step_pulse_input <= v;
        repeat (hold) @(posedge core_clk);
    endtask
    // Direction only changes well before the next step edge.
    task set_dir(input logic v);
        @(posedge core_clk);
        dir_pin <= v;
    endtask
endmodule

/* File: sim/tb_microstep_translator.sv */
// Self-checking bench for the micro-step translator.
// Assumes the controller model drives the pins and the bench is bus master.
`timescale 1ns/100ps
`include "mst_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_microstep_translator;
    logic               core_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]         wb_adr;
    logic [3:0]         wb_sel;
    logic [31:0]        wb_dat_w, wb_dat_r, rd;
    logic [6:0]         translator_position;
    mst_pkg::mst_coil_t coil_target;
    logic               pwm_period_tick, step_pulse_input, dir_pin, dirc_e, pol_e;
    logic [2:0]         mode_e, mode_p;
    int                 n_mismatch, cmp_count, pos_e, sz_e, cur_e;
    mst_ctl_model u_ctl (.core_clk(core_clk), .step_pulse_input(step_pulse_input),
        .dir_pin(dir_pin));
    mst_translator #(.PWM_CYCLES(8)) u_dut (.core_clk(core_clk), .rstn(rstn),
        .step_pulse_input(step_pulse_input), .dir_pin(dir_pin), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .translator_position(translator_position), .coil_target(coil_target),
        .pwm_period_tick(pwm_period_tick));
    // Free-running 100 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task close_out();
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One classic cycle; ack is read as sampled at the edge, before it updates.
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge core_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {1'b1, 1'b1, we, a, d};
        i = 0;
        do begin @(posedge core_clk); i++; end while (wb_ack !== 1'b1 && i < 20);
        rd = wb_dat_r;
        {wb_cyc, wb_stb, wb_we} <= 3'h0;
        if (i >= 20) begin n_mismatch++; close_out(); end
    endtask
    task set_ctrl(input logic [2:0] m, input logic dc, input logic pl);
        wb(1'b1, `MST_OFS_CTRL, {27'h0, pl, dc, m});
        {mode_p, dirc_e, pol_e} = {m, dc, pl};
        wb(1'b0, `MST_OFS_CTRL, 32'h0);
        `CHK("ctrl", {27'h0, pl, dc, m}, rd)
    endtask
    // Moves the pin and predicts the position; a mode change waits for this.
    task edge_to(input logic v);
        int sz;
        u_ctl.drive(v, 6);
        @(negedge core_clk);
        if (v != pol_e) begin
            sz = (mode_p > 3'h4) ? 32 : (1 << mode_p);
            if (sz < sz_e) pos_e = (pos_e + sz / 2) & ~(sz - 1);
            pos_e = ((dir_pin ^ dirc_e) ? pos_e + sz : pos_e - sz) & 127;
            {sz_e, mode_e} = {sz, mode_p};
        end
        `CHK("position", 7'(pos_e), translator_position)
    endtask
    task step_once();
        edge_to(!step_pulse_input);
        edge_to(!step_pulse_input);
    endtask
    task chk_pos();
        wb(1'b0, `MST_OFS_POSITION, 32'h0);
        `CHK("pos reg", {21'h0, mode_e, 1'b0, 7'(pos_e)}, rd)
    endtask
    // Only quarter-turn positions are checked, where the table is exact.
    task chk_coil();
        int i, x, y;
        x = (pos_e == 32) ? 1000 : (pos_e == 96) ? -1000 : 0;
        y = (pos_e == 0) ? 1000 : (pos_e == 64) ? -1000 : 0;
        i = 0;
        do begin @(negedge core_clk); i++; end while (pwm_period_tick !== 1'b1 && i < 20);
        if (i >= 20) begin n_mismatch++; close_out(); end
        @(negedge core_clk);
        `CHK("coil", {16'(y * cur_e), 16'(x * cur_e)}, coil_target)
    endtask
    task sc_reset();
        wb(1'b1, 8'h10, 32'hFFFF_FFFF);
        wb(1'b1, `MST_OFS_POSITION, 32'hFFFF_FFFF);
        for (int a = 0; a < 5; a++) begin
            wb(1'b0, 8'(a * 4), 32'h0);
            `CHK("reset reg", 32'h0, rd)
        end
    endtask
    task sc_wrap();
        set_ctrl(3'h5, 1'b0, 1'b0);
        wb(1'b1, `MST_OFS_CURRENT, 32'hFFFF_FFF5);
        cur_e = 21;
        wb(1'b0, `MST_OFS_CURRENT, 32'h0);
        `CHK("current", 32'h15, rd)
        chk_coil();
        repeat (4) begin
            step_once();
            chk_pos();
            chk_coil();
        end
    endtask
    task sc_dir();
        for (int k = 0; k < 4; k++) begin
            u_ctl.set_dir(k[0]);
            set_ctrl(3'h0, k[1], 1'b0);
            step_once();
        end
    endtask
    task sc_pol();
        set_ctrl(3'h0, 1'b0, 1'b1);
        repeat (2) step_once();
    endtask
    // Coarsening at 24 keeps the controller on shared points; 2, 36 and 46 do not.
    // shared-point coarsening kept.
    task sc_mode();
        logic [2:0] seq [9];
        seq = '{3'h4, 3'h2, 3'h3, 3'h2, 3'h3, 3'h1, 3'h6, 3'h7, 3'h5};
        for (int k = 0; k < 9; k++) begin
            set_ctrl(seq[k], 1'b0, 1'b0);
            chk_pos();
            step_once();
            chk_pos();
        end
    endtask
    // Reset for two cycles, then the scenarios in order.
    initial begin
        {n_mismatch, cmp_count, pos_e, sz_e, cur_e} = {32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
        {rstn, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_w} = {4'h0, 8'h00, 4'hF, 32'h0};
        {mode_p, mode_e, dirc_e, pol_e} = 8'h00;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        sc_reset();
        sc_wrap();
        sc_dir();
        sc_pol();
        sc_mode();
        close_out();
    end
endmodule
